// file: fppr_params.svh
`ifndef FPPR_PARAMS_SVH
`define FPPR_PARAMS_SVH

// Clock and the millisecond tick that paces every slow timer
`define FPPR_CLK_HZ 10000000
`define FPPR_TICK_US 1000
`define FPPR_TICK_CYC ((`FPPR_TICK_US * `FPPR_CLK_HZ) / 1000000)

// Timer lengths, counted in ticks
`define FPPR_MS_W 10
`define FPPR_DEBOUNCE_MS 10'h0014
`define FPPR_PGOOD_WAIT_MS 10'h01F4
`define FPPR_RESET_HOLD_MS 10'h0064

// Platform event inputs and log codes
`define FPPR_NUM_EVENTS 4
`define FPPR_LOG_CODE_W 4
`define FPPR_EV_OVER_TEMP 0
`define FPPR_EV_OVER_VOLT 1
`define FPPR_EV_FAN_FAIL 2
`define FPPR_EV_INTRUSION 3

`endif

// file: fppr_pkg.sv
package fppr_pkg;

  // One-cycle command from a command source
  typedef struct packed {
    logic valid;
    logic on;
    logic off;
    logic rst;
    logic force_fault;
    logic clear_fault;
  } fppr_cmd_t;

  // One record for the non-volatile event log writer
  typedef struct packed {
    logic valid;
    logic [3:0] code;
  } fppr_log_t;

  typedef enum logic [1:0] {
    S_OFF,
    S_PWR_UP,
    S_ON,
    S_RESET
  } fppr_state_t;

endpackage

// file: fppr_debounce.sv
`timescale 1ns/1ps
`include "fppr_params.svh"

module fppr_debounce #(
  parameter int N = 2,
  parameter logic [`FPPR_MS_W-1:0] DB_TICKS = `FPPR_DEBOUNCE_MS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_tick,
  // Raw switch levels, high while pressed
  input wire logic [N-1:0] i_raw,
  // Clean level and one pulse per press
  output logic [N-1:0] o_level,
  output logic [N-1:0] o_press
);

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_ch
      logic lvl_ff;
      logic nxt_lvl;
      logic press_ff;
      logic nxt_press;
      logic [`FPPR_MS_W-1:0] cnt_ff;
      logic [`FPPR_MS_W-1:0] nxt_cnt;

      // A level must hold for the full window before it counts
      always_comb begin
        nxt_lvl = lvl_ff;
        nxt_press = 1'b0;
        nxt_cnt = cnt_ff;
        if (i_raw[g] == lvl_ff) begin
          nxt_cnt = '0;
        end else if (i_tick) begin
          if (cnt_ff == DB_TICKS - 1'b1) begin
            nxt_cnt = '0;
            nxt_lvl = i_raw[g];
            nxt_press = i_raw[g];
          end else begin
            nxt_cnt = cnt_ff + 1'b1;
          end
        end
      end

      always_ff @(posedge i_clk) begin
        if (i_srst) begin
          lvl_ff <= 1'b0;
          press_ff <= 1'b0;
          cnt_ff <= '0;
        end else begin
          lvl_ff <= nxt_lvl;
          press_ff <= nxt_press;
          cnt_ff <= nxt_cnt;
        end
      end

      assign o_level[g] = lvl_ff;
      assign o_press[g] = press_ff;

      chk_press_once: assert property (@(posedge i_clk) disable iff (i_srst)
        press_ff |=> !press_ff [*2])
        else $error("press pulse repeated");
    end
  endgenerate

endmodule

// file: fppr_ctrl.sv
`timescale 1ns/1ps
`include "fppr_params.svh"

// Contract
// - Any request source commands power or reset.
// - Card requests obey secure mode setting.
// - Secure and powered: buttons cannot off/reset.
// - Button press in secure mode while powered flags violation.
// - Secure mode may blank video, protect floppy.
// - Failed power-on attempt lights fault indicator.
// - Supply failure lights fault indicator.
// - Bus force command lights fault indicator.
// - Management bus commands accepted from any master.
// - Platform events are recorded to the log.
// - Runs on standby, accepts power-on while off.
module fppr_ctrl #(
  parameter int TICK_CYC = `FPPR_TICK_CYC,
  parameter logic [`FPPR_MS_W-1:0] PGOOD_WAIT = `FPPR_PGOOD_WAIT_MS,
  parameter logic [`FPPR_MS_W-1:0] RESET_HOLD = `FPPR_RESET_HOLD_MS
) (
  // Standby clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Front panel switches, low while pressed
  input wire logic i_btn_power_n,
  input wire logic i_btn_reset_n,
  // Monitor card requests, low active
  input wire logic i_card_power_req_n,
  input wire logic i_card_reset_req_n,
  // Other wake and command sources
  input wire logic i_rtc_alarm,
  input wire logic i_net_wake,
  input wire fppr_pkg::fppr_cmd_t i_bus_cmd,
  input wire fppr_pkg::fppr_cmd_t i_console_cmd,
  input wire fppr_pkg::fppr_cmd_t i_host_cmd,
  input wire fppr_pkg::fppr_cmd_t i_wdt_cmd,
  // Supply status and secure mode
  input wire logic i_power_good,
  input wire logic i_secure_mode,
  // Configuration
  input wire logic i_cfg_card_in_secure,
  input wire logic i_cfg_blank_video,
  input wire logic i_cfg_floppy_wp,
  // Platform event levels
  input wire logic [`FPPR_NUM_EVENTS-1:0] i_plat_event,
  // Power, reset and indicators
  output logic o_power_en,
  output logic o_hard_reset,
  output logic o_fault_led,
  output logic o_powered,
  output logic o_sec_violation,
  output logic o_video_blank,
  output logic o_floppy_wp,
  // Event log records
  output fppr_pkg::fppr_log_t o_log
);

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond tick
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYC - 1);

  logic [TW-1:0] div_ff;
  logic [TW-1:0] nxt_div;
  logic tick_ff;
  logic nxt_tick;

  always_comb begin
    nxt_tick = (div_ff == TICK_LAST);
    nxt_div = nxt_tick ? '0 : div_ff + 1'b1;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Buttons and edge detection of the level sources
  logic [1:0] btn_press;
  logic card_pwr_ff;
  logic card_rst_ff;
  logic rtc_ff;
  logic wake_ff;

  fppr_debounce #(.N(2), .DB_TICKS(`FPPR_DEBOUNCE_MS)) u_db (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_tick(tick_ff),
    .i_raw({~i_btn_reset_n, ~i_btn_power_n}),
    .o_level(),
    .o_press(btn_press)
  );

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      card_pwr_ff <= 1'b0;
      card_rst_ff <= 1'b0;
      rtc_ff <= 1'b0;
      wake_ff <= 1'b0;
    end else begin
      card_pwr_ff <= ~i_card_power_req_n;
      card_rst_ff <= ~i_card_reset_req_n;
      rtc_ff <= i_rtc_alarm;
      wake_ff <= i_net_wake;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request merge
  fppr_pkg::fppr_state_t st_ff;
  fppr_pkg::fppr_state_t nxt_st;
  logic secure_act;
  logic card_ok;
  logic card_pwr_ev;
  logic card_rst_ev;
  logic cmd_on;
  logic cmd_off;
  logic cmd_rst;
  logic req_on;
  logic req_off;
  logic req_rst;
  logic force_fault;

  always_comb begin
    secure_act = i_secure_mode && (st_ff != fppr_pkg::S_OFF);
    card_ok = !secure_act || i_cfg_card_in_secure;
    card_pwr_ev = ~i_card_power_req_n && !card_pwr_ff && card_ok;
    card_rst_ev = ~i_card_reset_req_n && !card_rst_ff && card_ok;
    // Any master on the management bus reaches us through i_bus_cmd
    cmd_on = (i_bus_cmd.valid && i_bus_cmd.on) || (i_console_cmd.valid && i_console_cmd.on)
      || (i_host_cmd.valid && i_host_cmd.on) || (i_wdt_cmd.valid && i_wdt_cmd.on);
    cmd_off = (i_bus_cmd.valid && i_bus_cmd.off) || (i_console_cmd.valid && i_console_cmd.off)
      || (i_host_cmd.valid && i_host_cmd.off) || (i_wdt_cmd.valid && i_wdt_cmd.off);
    cmd_rst = (i_bus_cmd.valid && i_bus_cmd.rst) || (i_console_cmd.valid && i_console_cmd.rst)
      || (i_host_cmd.valid && i_host_cmd.rst) || (i_wdt_cmd.valid && i_wdt_cmd.rst);
    // The power button toggles; while off it only ever means power on
    req_on = btn_press[0] || card_pwr_ev || (i_rtc_alarm != rtc_ff)
      || (i_net_wake && !wake_ff) || cmd_on;
    req_off = (btn_press[0] && !secure_act) || card_pwr_ev || cmd_off;
    req_rst = (btn_press[1] && !secure_act) || card_rst_ev || cmd_rst;
    force_fault = i_bus_cmd.valid && i_bus_cmd.force_fault;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencer
  logic [`FPPR_MS_W-1:0] ms_ff;
  logic [`FPPR_MS_W-1:0] nxt_ms;
  logic fault_ff;
  logic nxt_fault;
  logic pwr_ff;
  logic nxt_pwr;
  logic rst_ff;
  logic nxt_rst;
  logic on_ff;
  logic nxt_on;
  logic viol_ff;
  logic nxt_viol;
  logic blank_ff;
  logic nxt_blank;
  logic fwp_ff;
  logic nxt_fwp;
  logic fault_set;
  logic fault_clr;

  always_comb begin
    nxt_st = st_ff;
    nxt_ms = ms_ff;
    fault_set = force_fault;
    fault_clr = i_bus_cmd.valid && i_bus_cmd.clear_fault;
    unique case (st_ff)
      // Standby logic stays live here, so power-on still works
      fppr_pkg::S_OFF: begin
        if (req_on) begin
          nxt_st = fppr_pkg::S_PWR_UP;
          nxt_ms = '0;
        end
      end
      fppr_pkg::S_PWR_UP: begin
        if (i_power_good) begin
          nxt_st = fppr_pkg::S_ON;
          fault_clr = 1'b1;
        end else if (tick_ff) begin
          if (ms_ff == PGOOD_WAIT - 1'b1) begin
            nxt_st = fppr_pkg::S_OFF;
            fault_set = 1'b1;
          end else begin
            nxt_ms = ms_ff + 1'b1;
          end
        end
      end
      fppr_pkg::S_ON: begin
        if (!i_power_good) begin
          nxt_st = fppr_pkg::S_OFF;
          fault_set = 1'b1;
        end else if (req_off) begin
          nxt_st = fppr_pkg::S_OFF;
        end else if (req_rst) begin
          nxt_st = fppr_pkg::S_RESET;
          nxt_ms = '0;
        end
      end
      fppr_pkg::S_RESET: begin
        if (!i_power_good) begin
          nxt_st = fppr_pkg::S_OFF;
          fault_set = 1'b1;
        end else if (req_off) begin
          nxt_st = fppr_pkg::S_OFF;
        end else if (tick_ff) begin
          if (ms_ff == RESET_HOLD - 1'b1) begin
            nxt_st = fppr_pkg::S_ON;
          end else begin
            nxt_ms = ms_ff + 1'b1;
          end
        end
      end
    endcase
    // A fault raised in the clearing cycle must survive
    nxt_fault = fault_set || (fault_ff && !fault_clr);
    nxt_pwr = (nxt_st != fppr_pkg::S_OFF);
    nxt_rst = (nxt_st == fppr_pkg::S_RESET);
    nxt_on = (nxt_st == fppr_pkg::S_ON) || (nxt_st == fppr_pkg::S_RESET);
    nxt_viol = (|btn_press) && secure_act;
    nxt_blank = secure_act && i_cfg_blank_video;
    nxt_fwp = secure_act && i_cfg_floppy_wp;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      st_ff <= fppr_pkg::S_OFF;
      ms_ff <= '0;
      fault_ff <= 1'b0;
      pwr_ff <= 1'b0;
      rst_ff <= 1'b0;
      on_ff <= 1'b0;
      viol_ff <= 1'b0;
      blank_ff <= 1'b0;
      fwp_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      ms_ff <= nxt_ms;
      fault_ff <= nxt_fault;
      pwr_ff <= nxt_pwr;
      rst_ff <= nxt_rst;
      on_ff <= nxt_on;
      viol_ff <= nxt_viol;
      blank_ff <= nxt_blank;
      fwp_ff <= nxt_fwp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Platform event logging
  logic [`FPPR_NUM_EVENTS-1:0] ev_ff;
  logic [`FPPR_NUM_EVENTS-1:0] pend_ff;
  logic [`FPPR_NUM_EVENTS-1:0] nxt_pend;
  fppr_pkg::fppr_log_t log_ff;
  fppr_pkg::fppr_log_t nxt_log;

  // Simultaneous events queue as pending bits, lowest index logged first
  always_comb begin
    nxt_pend = pend_ff | (i_plat_event & ~ev_ff);
    nxt_log = '0;
    for (int k = `FPPR_NUM_EVENTS - 1; k >= 0; k--) begin
      if (pend_ff[k]) begin
        nxt_log.valid = 1'b1;
        nxt_log.code = 4'(k);
      end
    end
    for (int k = 0; k < `FPPR_NUM_EVENTS; k++) begin
      if (nxt_log.valid && nxt_log.code == 4'(k) && !(i_plat_event[k] && !ev_ff[k])) begin
        nxt_pend[k] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      ev_ff <= '0;
      pend_ff <= '0;
      log_ff <= '0;
    end else begin
      ev_ff <= i_plat_event;
      pend_ff <= nxt_pend;
      log_ff <= nxt_log;
    end
  end

  assign o_power_en = pwr_ff;
  assign o_hard_reset = rst_ff;
  assign o_fault_led = fault_ff;
  assign o_powered = on_ff;
  assign o_sec_violation = viol_ff;
  assign o_video_blank = blank_ff;
  assign o_floppy_wp = fwp_ff;
  assign o_log = log_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_power_on_req: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_ff == fppr_pkg::S_OFF && req_on) |=> (st_ff == fppr_pkg::S_PWR_UP) && o_power_en)
    else $error("power-on request not taken");
  chk_reset_req: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_ff == fppr_pkg::S_ON && i_power_good && !req_off && req_rst) |=> o_hard_reset && o_power_en)
    else $error("reset request not taken");
  chk_card_gate: assert property (@(posedge i_clk) disable iff (i_srst)
    (secure_act && !i_cfg_card_in_secure) |-> !card_pwr_ev && !card_rst_ev)
    else $error("card request passed in secure mode");
  chk_secure_hold: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_ff == fppr_pkg::S_ON && i_secure_mode && i_power_good && !card_pwr_ev && !card_rst_ev
     && !cmd_off && !cmd_rst) |=> st_ff == fppr_pkg::S_ON)
    else $error("button acted in secure mode");
  chk_viol_flag: assert property (@(posedge i_clk) disable iff (i_srst)
    ((|btn_press) && i_secure_mode && st_ff != fppr_pkg::S_OFF) |=> o_sec_violation)
    else $error("violation not flagged");
  chk_video_blank: assert property (@(posedge i_clk) disable iff (i_srst)
    (o_video_blank || o_floppy_wp) |-> $past(secure_act))
    else $error("secure option active outside secure mode");
  chk_fault_timeout: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_ff == fppr_pkg::S_PWR_UP && tick_ff && ms_ff == PGOOD_WAIT - 1'b1 && !i_power_good)
    |=> o_fault_led && !o_power_en)
    else $error("failed power-on not flagged");
  chk_fault_supply: assert property (@(posedge i_clk) disable iff (i_srst)
    (st_ff == fppr_pkg::S_ON && !i_power_good) |=> o_fault_led ##0 st_ff == fppr_pkg::S_OFF)
    else $error("supply failure not flagged");
  chk_force_fault: assert property (@(posedge i_clk) disable iff (i_srst)
    force_fault |=> o_fault_led)
    else $error("forced fault ignored");
  chk_event_logged: assert property (@(posedge i_clk) disable iff (i_srst)
    (|(i_plat_event & ~ev_ff)) |-> ##[1:5] o_log.valid)
    else $error("platform event not logged");

endmodule

// file: fppr_supply_model.sv
`timescale 1ns/1ps

module fppr_supply_model #(
  parameter int DLY = 6
) (
  // Clock
  input wire logic i_clk,
  // Enable from the block and a fault commanded by the bench
  input wire logic i_power_en,
  input wire logic i_fail,
  // Supply good
  output logic o_power_good
);
  int cnt = 0;

  // Good comes up late and drops one clock after a fault is seen, never kinder than a real supply
  always @(posedge i_clk) begin
    cnt <= (i_power_en && !i_fail) ? cnt + 1 : 0;
    o_power_good <= (cnt >= DLY);
  end
endmodule

// file: test_fppr_ctrl.sv
`timescale 1ns/1ps

module test_fppr_ctrl;
  localparam int PW = 20;
  localparam int RH = 10;
  logic clk = 0, srst = 1, bp_n = 1, br_n = 1, cp_n = 1, cr_n = 1;
  logic rtc = 0, nw = 0, sec = 0, cc = 0, cv = 0, cf = 0, fail = 0, pg;
  logic [3:0] ev = '0;
  fppr_pkg::fppr_cmd_t bus = '0, con = '0, host = '0, wdt = '0;
  logic pe, hr, fl, pw, sv, vb, fw;
  fppr_pkg::fppr_log_t lg;
  int num_errors = 0, comparisons = 0, nviol = 0, nhr = 0, n;
  logic [3:0] codes[$];

  initial begin
    forever #50 clk = ~clk;
  end

  fppr_ctrl #(.TICK_CYC(4), .PGOOD_WAIT(10'h0014), .RESET_HOLD(10'h000A)) fppr_ctrl_inst (
    .i_clk(clk), .i_srst(srst), .i_btn_power_n(bp_n), .i_btn_reset_n(br_n),
    .i_card_power_req_n(cp_n), .i_card_reset_req_n(cr_n), .i_rtc_alarm(rtc), .i_net_wake(nw),
    .i_bus_cmd(bus), .i_console_cmd(con), .i_host_cmd(host), .i_wdt_cmd(wdt),
    .i_power_good(pg), .i_secure_mode(sec), .i_cfg_card_in_secure(cc), .i_cfg_blank_video(cv),
    .i_cfg_floppy_wp(cf), .i_plat_event(ev), .o_power_en(pe), .o_hard_reset(hr), .o_fault_led(fl),
    .o_powered(pw), .o_sec_violation(sv), .o_video_blank(vb), .o_floppy_wp(fw), .o_log(lg));

  fppr_supply_model fppr_supply_model_inst (.i_clk(clk), .i_power_en(pe), .i_fail(fail), .o_power_good(pg));

  always @(posedge clk) begin
    if (sv === 1'h1) nviol++;
    if (hr === 1'h1) nhr++;
    if (lg.valid === 1'h1) codes.push_back(lg.code);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(string nm, logic [3:0] seen, logic [3:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic sig(int k);
    case (k)
      0: return pe;
      1: return hr;
      2: return pw;
      default: return fl;
    endcase
  endfunction

  // Bounded wait on one output; a timeout ends the run
  task automatic wait_for(string nm, int k, logic v, int lim, output int cyc);
    cyc = 0;
    while (sig(k) !== v) begin
      if (cyc == lim) begin
        num_errors++;
        $display("unexpected %s: expected %h seen timeout", nm, v);
        give_verdict();
      end
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask

  // One-cycle command on source s: 0 bus, 1 console, 2 host, 3 watchdog
  task automatic cmd(int s, logic [4:0] f);
    @(posedge clk);
    case (s)
      0: bus <= {1'h1, f};
      1: con <= {1'h1, f};
      2: host <= {1'h1, f};
      default: wdt <= {1'h1, f};
    endcase
    @(posedge clk);
    bus <= '0;
    con <= '0;
    host <= '0;
    wdt <= '0;
    #1;
  endtask

  // Held well past the debounce time, then released just as long
  task automatic press(int b);
    @(posedge clk);
    if (b == 0) bp_n <= 1'h0;
    else br_n <= 1'h0;
    repeat (120) @(posedge clk);
    bp_n <= 1'h1;
    br_n <= 1'h1;
    repeat (120) @(posedge clk);
    #1;
  endtask

  task automatic up_from(int s);
    cmd(s, 5'h10);
    wait_for("power_en", 0, 1'h1, 2, n);
    wait_for("powered", 2, 1'h1, 20, n);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_sources();
    for (int s = 0; s < 4; s++) begin
      up_from(s);
      cmd(s, 5'h08);
      wait_for("power_off", 0, 1'h0, 2, n);
    end
    @(posedge clk);
    nw <= 1'h1;
    wait_for("net_wake", 2, 1'h1, 24, n);
    cmd(0, 5'h08);
    @(posedge clk);
    rtc <= 1'h1;
    wait_for("rtc_alarm", 2, 1'h1, 24, n);
  endtask

  task automatic t_reset_hold();
    cmd(2, 5'h04);
    wait_for("hard_reset", 1, 1'h1, 2, n);
    check("powered", pw, 1'h1);
    wait_for("reset_end", 1, 1'h0, RH * 4 + 8, n);
    check("reset_long", n >= (RH - 1) * 4, 1'h1);
  endtask

  task automatic t_secure();
    int v0, h0;
    sec <= 1'h1;
    cv <= 1'h1;
    cf <= 1'h1;
    repeat (4) @(posedge clk);
    check("video_blank", vb, 1'h1);
    check("floppy_wp", fw, 1'h1);
    v0 = nviol;
    h0 = nhr;
    press(1);
    press(0);
    check("sec_power", pe, 1'h1);
    check("sec_reset", nhr == h0, 1'h1);
    check("violations", nviol - v0, 4'h2);
    @(posedge clk);
    cr_n <= 1'h0;
    @(posedge clk);
    cr_n <= 1'h1;
    repeat (5) @(posedge clk);
    check("card_blocked", nhr == h0, 1'h1);
    cc <= 1'h1;
    cr_n <= 1'h0;
    @(posedge clk);
    cr_n <= 1'h1;
    wait_for("card_reset", 1, 1'h1, 4, n);
    wait_for("card_end", 1, 1'h0, RH * 4 + 8, n);
    @(posedge clk);
    sec <= 1'h0;
    repeat (3) @(posedge clk);
    check("video_clear", vb, 1'h0);
  endtask

  task automatic t_button();
    int v0;
    v0 = nviol;
    press(0);
    check("btn_off", pe, 1'h0);
    press(0);
    check("btn_on", pe, 1'h1);
    check("no_violation", nviol == v0, 1'h1);
    // Card power line toggles: off from on, then on again
    @(posedge clk);
    cp_n <= 1'h0;
    @(posedge clk);
    cp_n <= 1'h1;
    wait_for("card_off", 0, 1'h0, 4, n);
    @(posedge clk);
    cp_n <= 1'h0;
    @(posedge clk);
    cp_n <= 1'h1;
    wait_for("card_on", 2, 1'h1, 20, n);
  endtask

  task automatic t_faults();
    wait_for("powered", 2, 1'h1, 20, n);
    @(posedge clk);
    fail <= 1'h1;
    wait_for("supply_fail", 3, 1'h1, 6, n);
    // Clear first, so the timeout alone must light the indicator
    cmd(0, 5'h01);
    wait_for("pre_clear", 3, 1'h0, 2, n);
    cmd(0, 5'h08);
    cmd(0, 5'h10);
    wait_for("try_on", 0, 1'h1, 2, n);
    wait_for("timeout", 0, 1'h0, PW * 4 + 8, n);
    check("fault_led", fl, 1'h1);
    @(posedge clk);
    fail <= 1'h0;
    cmd(0, 5'h01);
    wait_for("clear", 3, 1'h0, 2, n);
    cmd(0, 5'h02);
    wait_for("force", 3, 1'h1, 2, n);
    up_from(0);
    check("fault_cleared", fl, 1'h0);
  endtask

  task automatic t_events();
    @(posedge clk);
    ev <= 4'h5;
    repeat (6) @(posedge clk);
    check("log_count", codes.size(), 4'h2);
    check("log_first", codes[0], 4'h0);
    check("log_second", codes[1], 4'h2);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    #1;
    check("reset_outputs", {pe, hr, fl, sv}, 4'h0);
    t_sources();
    t_reset_hold();
    t_secure();
    t_button();
    t_faults();
    t_events();
    give_verdict();
  end
endmodule
